//--- dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tef_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, trg = 1'b0, gated = 1'b0;
  logic [7:0]  paddr = '0;
  logic [11:0] src = '0;
  logic [15:0] cnt = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [31:0] exp_q[$];
  logic        ld;
  logic [15:0] ldv, arv;
  logic [15:0] ld_q[$];
  int          errors = 0, checks = 0;
  // ctrl, pulsed sources, expected flags
  localparam logic [39:0] T [15] = '{40'h0000_01_0002, 40'h0000_02_0004, 40'h0000_04_0008,
    40'h0000_08_0010, 40'h0000_10_0001, 40'h0000_20_0001, 40'h0000_40_0001, 40'h0000_80_0020,
    40'h0020_01_0000, 40'h0002_10_0000, 40'h0002_20_0000, 40'h0004_20_0000, 40'h0004_40_0000,
    40'h0004_10_0001, 40'h0200_01_0000};
  // brake pin tied off: its synchroniser is not exercised here
  tef_event_flags #(.CNT_W(16)) tef_event_flags_i (.ref_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .compare_match(src[3:0]), .rep_wrap(src[4]),
    .counter_reinit(src[5]), .trigger_reinit(src[6]), .hw_commutation(src[7]),
    .capture_strobe(src[11:8]), .brake_pin(1'b0), .trigger_input(trg), .gated_mode(gated),
    .core_counter(cnt), .main_output_enable(), .update_event(), .trigger_event(),
    .commutation_event(), .preload_load_chan123(), .prescaler_clear(), .counter_load(ld),
    .counter_load_value(ldv), .compare_event(), .capture1_value());
  initial forever #50 ref_clk = ~ref_clk;
  task automatic end_of_test();
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one apb transfer; idle edge after it so no signal is driven twice in a step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, '0);
  endtask
  task automatic pulse(input logic [11:0] s);
    src <= s;
    @(posedge ref_clk);
    src <= '0;
    @(posedge ref_clk);
  endtask
  // scoreboard: oldest note against each completed read
  always @(posedge ref_clk) if (psel && penable && !pwrite && pready === 1'b1) begin
    checks++;
    if (prdata !== exp_q[0]) begin
      errors++;
      $display("mismatch prdata@%h exp %h got %h", paddr, exp_q[0], prdata);
    end
    void'(exp_q.pop_front());
  end
  // forced update: counter reload value against the oldest note
  always @(posedge ref_clk) if (ld === 1'b1) begin
    checks++;
    if (ldv !== ld_q[0]) begin
      errors++;
      $display("mismatch counter_load_value exp %h got %h", ld_q[0], ldv);
    end
    void'(ld_q.pop_front());
  end
  initial begin
    #1000000;
    errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h2dd6f70b));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(TEF_OFS_FLAGS, '0);
    rd(TEF_OFS_EVGEN, '0);
    wr(8'h08, 32'hffff);
    ld_q.push_back(16'h0000);
    wr(TEF_OFS_EVGEN, 32'h1);
    wr(TEF_OFS_EVGEN, 32'h0);
    rd(TEF_OFS_FLAGS, 32'h1);
    wr(TEF_OFS_EVGEN, 32'h7e);
    rd(TEF_OFS_FLAGS, 32'h7f);
    wr(TEF_OFS_FLAGS, 32'hfffe);
    rd(TEF_OFS_FLAGS, 32'h7e);
    wr(TEF_OFS_FLAGS, '0);
    wr(TEF_OFS_CTRL, 32'h8000);
    wr(TEF_OFS_EVGEN, 32'h80);
    rd(TEF_OFS_FLAGS, 32'h80);
    rd(TEF_OFS_CTRL, '0);
    wr(TEF_OFS_FLAGS, '0);
    // hardware sources under each control setting
    foreach (T[i]) begin
      wr(TEF_OFS_CTRL, {16'h0, T[i][39:24]});
      pulse({4'h0, T[i][23:16]});
      rd(TEF_OFS_FLAGS, {16'h0, T[i][15:0]});
      wr(TEF_OFS_FLAGS, '0);
    end
    // channel 1 as input: capture, overcapture, clear by read
    wr(TEF_OFS_CTRL, 32'h200);
    cnt <= 16'($urandom);
    pulse(12'h100);
    pulse(12'h100);
    rd(TEF_OFS_FLAGS, 32'h202);
    rd(TEF_OFS_CAP1, {16'h0, cnt});
    rd(TEF_OFS_FLAGS, 32'h200);
    wr(TEF_OFS_FLAGS, '0);
    cnt <= 16'($urandom);
    wr(TEF_OFS_EVGEN, 32'h2);
    wr(TEF_OFS_EVGEN, 32'h2);
    rd(TEF_OFS_FLAGS, 32'h202);
    rd(TEF_OFS_CAP1, {16'h0, cnt});
    // trigger pin: rising edge, then falling edge in gated mode
    wr(TEF_OFS_CTRL, '0);
    wr(TEF_OFS_FLAGS, '0);
    trg <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(TEF_OFS_FLAGS, 32'h40);
    wr(TEF_OFS_FLAGS, '0);
    gated <= 1'b1;
    trg <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(TEF_OFS_FLAGS, 32'h40);
    // down counting: forced update loads the reload value
    arv = 16'($urandom);
    wr(TEF_OFS_CTRL, 32'h10);
    wr(TEF_OFS_ARLD, {16'h0, arv});
    ld_q.push_back(arv);
    wr(TEF_OFS_EVGEN, 32'h1);
    rd(TEF_OFS_FLAGS, 32'h41);
    end_of_test();
  end
endmodule

//--- dv/tef_chk.sv
module tef_chk
  import tef_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        main_output_enable,
  input wire logic        update_event,
  input wire logic        trigger_event,
  input wire logic        commutation_event,
  input wire logic        prescaler_clear,
  input wire logic        counter_load,
  input wire logic [3:0]  compare_event
);
  // decode of accepted writes and of the address map
  wire ev  = psel && penable && pwrite && paddr == TEF_OFS_EVGEN;
  wire map = paddr inside {TEF_OFS_CTRL, TEF_OFS_FLAGS, TEF_OFS_EVGEN,
                           TEF_OFS_COUNT, TEF_OFS_ARLD, TEF_OFS_CAP1};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_UPD: assert property (ev && pwdata[0] |=> update_event)
    else $error("forced update missing");
  AST_PSC: assert property (ev && pwdata[0] |=> prescaler_clear ##1 !prescaler_clear)
    else $error("prescaler clear not one cycle");
  AST_TRG: assert property (ev && pwdata[6] |=> trigger_event)
    else $error("forced trigger missing");
  AST_COM: assert property (ev && pwdata[5] |=> commutation_event ##1 !commutation_event)
    else $error("forced commutation wrong");
  AST_BRK: assert property (ev && pwdata[7] |-> ##[1:2] !main_output_enable)
    else $error("brake left outputs enabled");
  AST_CH4: assert property (ev && pwdata[4] |=> compare_event[3])
    else $error("channel 4 event missing");
  AST_ERR: assert property (psel && penable && !map |-> pslverr)
    else $error("unmapped access not refused");
  AST_OKR: assert property (pslverr |-> psel && penable && !map)
    else $error("spurious slave error");
  AST_LDC: assert property (counter_load |-> prescaler_clear && update_event)
    else $error("forced update without prescaler clear");
endmodule

bind tef_event_flags tef_chk tef_chk_i (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pslverr, .main_output_enable, .update_event, .trigger_event, .commutation_event,
  .prescaler_clear, .counter_load, .compare_event);

//--- rtl/tef_event_flags.sv
// Contract
// - commutation flag at bit 5 sets on commutation, cleared by software zero write
// - commutation event loads output enables and modes from preload copies
// - output channel 1 flag sets on compare match, not in center-aligned mode
// - input channel 1 flag sets on capture; cleared by zero write or capture read
// - channel 2..4 flags at bits 2..4 behave like channel 1; code clears only channel 1 on a capture read
// - update flag bit 0 sets on update event, only zero write clears
// - repetition overflow or underflow updates when update disable is zero
// - software force or counter reinit updates when source select and disable zero
// - trigger reinit of counter updates when source select and disable zero
// - brake force clears main output enable and sets brake flag
// - trigger force sets trigger flag; bit self-clears
// - commutation force loads preload copies when preload control is one
// - software commutation affects channels 1 to 3 only
// - output channel force sets channel flag; bit self-clears
// - input channel force captures counter, sets flag or overcapture flag
// - force bits 4..2 act on channels 4..2 as for channel 1; code captures the counter for channel 1 only, channels 2..4 only set flags
// - update force reinitializes counter and generates update
// - forced update clears prescaler counter, keeps division factor
// - forced update zeroes counter up or center, loads reload when down; code loads reload whenever direction is down, center-aligned too
// - overcapture flag sets on capture with channel flag still set
// - trigger on valid edge outside gated mode, either edge in gated mode
module tef_event_flags
  import tef_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [3:0]       compare_match,
  input  wire logic [3:0]       capture_strobe,
  input  wire logic             rep_wrap,
  input  wire logic             counter_reinit,
  input  wire logic             brake_pin,
  input  wire logic             trigger_input,
  input  wire logic             gated_mode,
  input  wire logic             trigger_reinit,
  input  wire logic             hw_commutation,
  input  wire logic [CNT_W-1:0] core_counter,
  output logic                  main_output_enable,
  output logic                  update_event,
  output logic                  trigger_event,
  output logic                  commutation_event,
  output logic                  preload_load_chan123,
  output logic                  prescaler_clear,
  output logic                  counter_load,
  output logic      [CNT_W-1:0] counter_load_value,
  output logic      [3:0]       compare_event,
  output logic      [15:0]      capture1_value
);

  logic [15:0]      flags_q;
  logic [15:0]      flags_d;
  logic [15:0]      ctrl_q;
  logic [CNT_W-1:0] arld_q;
  logic [CNT_W-1:0] cap1_q;
  logic [7:0]       force_q;
  logic [2:0]       trg_sync_q;
  logic [2:0]       brk_sync_q;
  logic             trg_prev_q;

  // apb decode: zero wait states, unmapped offsets flag an error
  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire hit_flg  = paddr == TEF_OFS_FLAGS;
  wire hit_evg  = paddr == TEF_OFS_EVGEN;
  wire hit_ctl  = paddr == TEF_OFS_CTRL;
  wire hit_cnt  = paddr == TEF_OFS_COUNT;
  wire hit_arl  = paddr == TEF_OFS_ARLD;
  wire hit_cap  = paddr == TEF_OFS_CAP1;
  wire mapped   = hit_flg | hit_evg | hit_ctl | hit_cnt | hit_arl | hit_cap;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // control fields
  wire update_disable   = ctrl_q[TEF_C_UPDATE_DISABLE];
  wire update_request_source    = ctrl_q[TEF_C_URS];
  wire down   = ctrl_q[TEF_C_DIR];
  wire center = ctrl_q[TEF_C_CMS];
  wire commutation_preload_control   = ctrl_q[TEF_C_COMMUTATION_PRELOAD_CONTROL];
  wire [3:0] chan_in = ctrl_q[TEF_C_CHIN +: TEF_NCH];

  // force strobes held for one cycle only
  wire f_upd = force_q[TEF_B_UPD];
  wire f_com = force_q[TEF_B_COM];
  wire f_trg = force_q[TEF_B_TRG];
  wire f_brk = force_q[TEF_B_BRK];
  wire [3:0] f_ch = force_q[TEF_B_CH1 +: TEF_NCH];

  // trigger pin edges and brake pin level judged only on agreeing second and third stages
  wire trg_lvl  = trg_sync_q[2];
  wire trg_edge = (trg_sync_q[1] == trg_sync_q[2]) && (trg_lvl != trg_prev_q);
  wire trg_pin_evt = trg_edge && (gated_mode || trg_lvl);
  wire brk_pin  = (brk_sync_q[1] == brk_sync_q[2]) && brk_sync_q[2];

  assign trigger_event = trg_pin_evt | f_trg;
  wire reinit_ok = !update_request_source && !update_disable;
  assign update_event = (!update_disable && rep_wrap)
                      | (reinit_ok && (f_upd || counter_reinit))
                      | (reinit_ok && trigger_reinit);
  // forced update restarts prescaler and counter; factor is elsewhere
  assign prescaler_clear    = f_upd;
  assign counter_load       = f_upd;
  assign counter_load_value = down ? arld_q : '0;
  assign commutation_event  = hw_commutation | f_com;
  // channel 4 has no complementary pair, so only 1..3 are reloaded
  assign preload_load_chan123 = hw_commutation | (f_com && commutation_preload_control);
  // output compare match suppressed in center-aligned mode
  wire [3:0] cmp_hit = compare_match & ~chan_in & {TEF_NCH{!center}};
  wire [3:0] cap_hit = (capture_strobe | f_ch) & chan_in;
  wire [3:0] ch_set  = cmp_hit | (f_ch & ~chan_in) | cap_hit;
  assign compare_event = ch_set;
  wire cap1_read = acc && !pwrite && hit_cap;
  wire [15:0] wclr = (wr && hit_flg) ? ~pwdata[15:0] : TEF_RST16;

  // flag next state: set beats a same-cycle clear
  always_comb begin
    flags_d = flags_q & ~wclr;
    if (cap1_read && chan_in[0]) begin
      flags_d[TEF_B_CH1] = 1'b0;
    end
    for (int i = 0; i < TEF_NCH; i++) begin
      if (cap_hit[i] && flags_q[TEF_B_CH1+i]) begin
        flags_d[TEF_B_OVC1+i] = 1'b1;
      end
      if (ch_set[i]) begin
        flags_d[TEF_B_CH1+i] = 1'b1;
      end
    end
    if (update_event) begin
      flags_d[TEF_B_UPD] = 1'b1;
    end
    if (commutation_event) begin
      flags_d[TEF_B_COM] = 1'b1;
    end
    if (trigger_event) begin
      flags_d[TEF_B_TRG] = 1'b1;
    end
    if (f_brk || brk_pin) begin
      flags_d[TEF_B_BRK] = 1'b1;
    end
    flags_d = flags_d & TEF_FLAGS_MASK;
  end

  // read mux; event generation reads as zero
  always_comb begin
    prdata = '0;
    if (hit_flg) begin
      prdata[15:0] = flags_q;
    end else if (hit_ctl) begin
      prdata[15:0] = ctrl_q;
    end else if (hit_cnt) begin
      prdata[CNT_W-1:0] = core_counter;
    end else if (hit_arl) begin
      prdata[CNT_W-1:0] = arld_q;
    end else if (hit_cap) begin
      prdata[CNT_W-1:0] = cap1_q;
    end
  end

  // synchronisers for pin inputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trg_sync_q <= '0;
      brk_sync_q <= '0;
      trg_prev_q <= 1'b0;
    end else begin
      trg_sync_q <= {trg_sync_q[1:0], trigger_input};
      brk_sync_q <= {brk_sync_q[1:0], brake_pin};
      if (trg_sync_q[1] == trg_sync_q[2]) begin
        trg_prev_q <= trg_lvl;
      end
    end
  end

  // force bits live one cycle, zeros written do nothing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      force_q <= '0;
    end else begin
      force_q <= (wr && hit_evg) ? pwdata[7:0] : 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= TEF_RST16;
    end else begin
      flags_q <= flags_d;
    end
  end

  // control and reload; brake drops main output enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= TEF_RST16;
      arld_q <= '0;
    end else begin
      if (wr && hit_ctl) begin
        ctrl_q <= pwdata[15:0] & TEF_CTRL_MASK;
      end
      if (f_brk || brk_pin) begin
        ctrl_q[TEF_C_MOE] <= 1'b0;
      end
      if (wr && hit_arl) begin
        arld_q <= pwdata[CNT_W-1:0];
      end
    end
  end

  // channel 1 capture register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap1_q <= '0;
    end else if (cap_hit[0]) begin
      cap1_q <= core_counter;
    end
  end

  assign main_output_enable = ctrl_q[TEF_C_MOE];
  assign capture1_value     = cap1_q;

endmodule

//--- rtl/tef_pkg.sv
package tef_pkg;
  // register byte offsets
  localparam logic [7:0] TEF_OFS_FLAGS = 8'h10;
  localparam logic [7:0] TEF_OFS_EVGEN = 8'h14;
  localparam logic [7:0] TEF_OFS_CTRL  = 8'h00;
  localparam logic [7:0] TEF_OFS_COUNT = 8'h24;
  localparam logic [7:0] TEF_OFS_ARLD  = 8'h2c;
  localparam logic [7:0] TEF_OFS_CAP1  = 8'h34;
  // flag and force bit positions
  localparam int TEF_B_UPD   = 0;
  localparam int TEF_B_CH1   = 1;
  localparam int TEF_B_COM   = 5;
  localparam int TEF_B_TRG   = 6;
  localparam int TEF_B_BRK   = 7;
  localparam int TEF_B_OVC1  = 9;
  // control register bits
  localparam int TEF_C_UPDATE_DISABLE  = 1;
  localparam int TEF_C_URS   = 2;
  localparam int TEF_C_DIR   = 4;
  localparam int TEF_C_CMS   = 5;
  localparam int TEF_C_COMMUTATION_PRELOAD_CONTROL  = 8;
  localparam int TEF_C_MOE   = 15;
  localparam int TEF_C_CHIN  = 9;
  localparam int TEF_NCH     = 4;
  localparam logic [15:0] TEF_FLAGS_MASK = 16'h1eff;
  localparam logic [15:0] TEF_CTRL_MASK  = 16'h9f36;
  localparam logic [15:0] TEF_RST16      = 16'h0000;
endpackage
